// *** rtl/pesc_pkg.sv ***
package pesc_pkg;

   // register byte offsets on the apb slave
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_CNT_LO = 12'h004;
   localparam logic [11:0] OFS_CNT_HI = 12'h008;
   localparam logic [11:0] OFS_STAT   = 12'h00c;

   // control register field positions, and the status hit bit
   localparam int unsigned CTL_EVT_LSB   = 0;
   localparam int unsigned CTL_UM_LSB    = 8;
   localparam int unsigned CTL_EDGE_BIT  = 18;
   localparam int unsigned CTL_EN_BIT    = 22;
   localparam int unsigned CTL_CMASK_LSB = 24;
   localparam int unsigned STAT_HIT_BIT  = 16;

   // reset values
   localparam logic [7:0]  RST_EVT   = 8'h00;
   localparam logic [7:0]  RST_UMASK = 8'h00;
   localparam logic [7:0]  RST_CMASK = 8'h00;
   localparam logic [47:0] RST_COUNT = 48'h0000_0000_0000;

   // widths
   localparam int unsigned CNT_W  = 48;
   localparam int unsigned HI_W   = CNT_W - 32;
   localparam int unsigned LANE_W = 6;
   localparam int unsigned SUM_W  = 9;

   // event numbers
   localparam logic [7:0] EV_ST_XLATE  = 8'h49;
   localparam logic [7:0] EV_FB_HIT    = 8'h4c;
   localparam logic [7:0] EV_L1_FILL   = 8'h51;
   localparam logic [7:0] EV_MOV_ELIM  = 8'h58;
   localparam logic [7:0] EV_RING      = 8'h5c;
   localparam logic [7:0] EV_RS_EMPTY  = 8'h5e;
   localparam logic [7:0] EV_OFFCORE   = 8'h60;
   localparam logic [7:0] EV_LOCK      = 8'h63;
   localparam logic [7:0] EV_DECQ      = 8'h79;

   typedef enum logic [1:0] {
      PESC_REG_CTRL,
      PESC_REG_CNT_LO,
      PESC_REG_CNT_HI,
      PESC_REG_STAT
   } pesc_reg_t;

   // eight lanes, one per unit mask bit
   typedef logic [7:0][LANE_W-1:0] pesc_lanes_t;

   // per-cycle event sources from pipeline and memory subsystem
   typedef struct packed {
      logic       walk_done_4k;
      logic       walk_done_2m4m;
      logic       walk_done_1g;
      logic       page_miss_walker_busy_st;
      logic       l2x_hit_4k;
      logic       l2x_hit_2m;
      logic       dir_cache_miss_st;
      logic       fb_hit_sw_pf;
      logic       fb_hit_hw_pf;
      logic       first_level_line_fill;
      logic [2:0] mov_int_elim;
      logic [2:0] mov_simd_elim;
      logic [2:0] mov_int_kept;
      logic [2:0] mov_simd_kept;
      logic       unhalted;
      logic       ring0;
      logic       station_empty;
      logic [5:0] sq_demand_data;
      logic [5:0] sq_demand_code;
      logic [5:0] sq_rfo;
      logic [5:0] sq_all_data;
      logic       lock_l1_l2;
      logic       lock_l1;
      logic       decq_empty;
      logic [2:0] legacy_uops;
      logic [2:0] dcache_uops;
      logic [2:0] ms_dcache_uops;
      logic [2:0] ms_legacy_uops;
   } pesc_events_t;

   typedef struct packed {
      logic [7:0]       evt;
      logic [7:0]       umask;
      logic [7:0]       cmask;
      logic             edge_en;
      logic             cnt_en;
      logic [CNT_W-1:0] count;
      logic             prev_hit;
      logic [SUM_W-1:0] last_sum;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
   } pesc_state_t;

endpackage

// *** rtl/pesc_counter.sv ***
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps

module pesc_counter
   import pesc_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   input  wire logic [3:0]   pstrb,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire pesc_events_t ev
);

   // r is the registered state, n its next value
   pesc_state_t r;
   pesc_state_t n;

   pesc_lanes_t           lanes;
   logic [7:0][SUM_W-1:0] gated;
   logic [SUM_W-1:0]      ev_sum;
   logic                  hit;
   logic [SUM_W-1:0]      inc;
   logic                  cmask_on;
   logic                  map_ok;
   pesc_reg_t             sel;
   logic [31:0]           cur;
   logic [31:0]           ctrl_word;
   logic [31:0]           hi_word;
   // apb phases: the first access edge takes, the next one completes
   logic                  acc_first;
   logic                  acc_last;
   logic                  wr_commit;

   // lane widening keeps every adder input at one width
   function automatic logic [LANE_W-1:0] ext1(input logic b);
      return {{(LANE_W-1){1'b0}}, b};
   endfunction

   function automatic logic [LANE_W-1:0] ext3(input logic [2:0] v);
      return {{(LANE_W-3){1'b0}}, v};
   endfunction

   // adds the lanes that survived the unit mask gate
   function automatic logic [SUM_W-1:0] lane_sum(input logic [7:0][SUM_W-1:0] l);
      logic [SUM_W-1:0] s;
      s = '0;
      for (int i = 0; i < 8; i++) begin
         s = s + l[i];
      end
      return s;
   endfunction

   // address decode, shared by the read and write paths
   function automatic logic reg_decode(input  logic [11:0] a,
                                       output pesc_reg_t   s);
      s = PESC_REG_CTRL;
      unique case (a)
         OFS_CTRL: begin
            s = PESC_REG_CTRL;
            return 1'b1;
         end
         OFS_CNT_LO: begin
            s = PESC_REG_CNT_LO;
            return 1'b1;
         end
         OFS_CNT_HI: begin
            s = PESC_REG_CNT_HI;
            return 1'b1;
         end
         OFS_STAT: begin
            s = PESC_REG_STAT;
            return 1'b1;
         end
         default: begin
            // unmapped or unaligned words are refused
            return 1'b0;
         end
      endcase
   endfunction

   function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
      logic [31:0] v;
      v = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            v[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return v;
   endfunction

   // control word image, shared by the read mux and the write merge
   function automatic logic [31:0] ctrl_pack(input pesc_state_t s);
      logic [31:0] w;
      w = '0;
      w[CTL_EVT_LSB +: 8]   = s.evt;
      w[CTL_UM_LSB +: 8]    = s.umask;
      w[CTL_EDGE_BIT]       = s.edge_en;
      w[CTL_EN_BIT]         = s.cnt_en;
      w[CTL_CMASK_LSB +: 8] = s.cmask;
      return w;
   endfunction

   // upper counter bits, zero-extended to a bus word
   function automatic logic [31:0] hi_pack(input logic [CNT_W-1:0] c);
      return {{(32-HI_W){1'b0}}, c[CNT_W-1:32]};
   endfunction

   // status word: last per-cycle sum and last threshold condition
   function automatic logic [31:0] stat_pack(input pesc_state_t s);
      logic [31:0] w;
      w = '0;
      w[SUM_W-1:0]    = s.last_sum;
      w[STAT_HIT_BIT] = s.prev_hit;
      return w;
   endfunction

   // threshold condition; a zero threshold means any activity at all
   function automatic logic cond_met(input logic [SUM_W-1:0] s,
                                     input logic [7:0]       c);
      if (c != 8'h00) begin
         return s >= {{(SUM_W-8){1'b0}}, c};
      end
      return s != '0;
   endfunction

   // event source routing into unit-mask lanes
   always_comb begin
      lanes = '0;
      unique case (r.evt)
         EV_ST_XLATE: begin
            lanes[1] = ext1(ev.walk_done_4k);
            lanes[2] = ext1(ev.walk_done_2m4m);
            lanes[3] = ext1(ev.walk_done_1g);
            lanes[4] = ext1(ev.page_miss_walker_busy_st);
            lanes[5] = ext1(ev.l2x_hit_4k);
            lanes[6] = ext1(ev.l2x_hit_2m);
            lanes[7] = ext1(ev.dir_cache_miss_st);
         end
         EV_FB_HIT: begin
            lanes[0] = ext1(ev.fb_hit_sw_pf);
            lanes[1] = ext1(ev.fb_hit_hw_pf);
         end
         EV_L1_FILL: begin
            lanes[0] = ext1(ev.first_level_line_fill);
         end
         EV_MOV_ELIM: begin
            lanes[0] = ext3(ev.mov_int_elim);
            lanes[1] = ext3(ev.mov_simd_elim);
            lanes[2] = ext3(ev.mov_int_kept);
            lanes[3] = ext3(ev.mov_simd_kept);
         end
         EV_RING: begin
            lanes[0] = ext1(ev.unhalted & ev.ring0);
            lanes[1] = ext1(ev.unhalted & ~ev.ring0);
         end
         EV_RS_EMPTY: begin
            lanes[0] = ext1(ev.station_empty);
         end
         EV_OFFCORE: begin
            lanes[0] = ev.sq_demand_data;
            lanes[1] = ev.sq_demand_code;
            lanes[2] = ev.sq_rfo;
            lanes[3] = ev.sq_all_data;
         end
         EV_LOCK: begin
            lanes[0] = ext1(ev.lock_l1_l2);
            lanes[1] = ext1(ev.lock_l1);
         end
         EV_DECQ: begin
            lanes[1] = ext1(ev.decq_empty);
            lanes[2] = ext3(ev.legacy_uops);
            lanes[3] = ext3(ev.dcache_uops);
            lanes[4] = ext3(ev.ms_dcache_uops);
            lanes[5] = ext3(ev.ms_legacy_uops);
         end
         default: begin
            // unknown event numbers count nothing
            lanes = '0;
         end
      endcase
   end

   // gating before the adder lets several mask bits sum their lanes
   // mask bits gate lanes
   for (genvar g = 0; g < 8; g++) begin : g_gate
      assign gated[g] = r.umask[g] ? {{(SUM_W-LANE_W){1'b0}}, lanes[g]} : '0;
   end

   always_comb begin
      n        = r;

      ev_sum   = lane_sum(gated);
      cmask_on = (r.cmask != 8'h00);
      hit      = cond_met(ev_sum, r.cmask);
      if (r.edge_en) begin
         inc = {{(SUM_W-1){1'b0}}, hit & ~r.prev_hit};
      end else if (cmask_on) begin
         inc = {{(SUM_W-1){1'b0}}, hit};
      end else begin
         inc = ev_sum;
      end
      n.prev_hit = hit;
      n.last_sum = ev_sum;
      // the 48-bit count wraps silently; no overflow is kept here
      if (r.cnt_en) begin
         n.count = r.count + {{(CNT_W-SUM_W){1'b0}}, inc};
      end

      // register decode and read mux
      map_ok    = reg_decode(paddr, sel);
      ctrl_word = ctrl_pack(r);
      hi_word   = hi_pack(r.count);
      unique case (sel)
         PESC_REG_CTRL: begin
            cur = ctrl_word;
         end
         PESC_REG_CNT_LO: begin
            cur = r.count[31:0];
         end
         PESC_REG_CNT_HI: begin
            cur = hi_word;
         end
         PESC_REG_STAT: begin
            cur = stat_pack(r);
         end
      endcase

      // one wait state: pready rises in the second access cycle
      acc_first = psel & penable & ~r.pready;
      acc_last  = psel & penable & r.pready;
      wr_commit = acc_last & pwrite & map_ok;
      n.pready  = acc_first;
      n.pslverr = acc_first & ~map_ok;
      // read data is caught at the taking edge, so lo and hi may tear
      if (acc_first) begin
         n.prdata = (map_ok & ~pwrite) ? cur : 32'h0000_0000;
      end else begin
         // the bus word stands only while pready does
         n.prdata = 32'h0000_0000;
      end

      // writes land at the edge that completes the transfer
      if (wr_commit) begin
         unique case (sel)
            PESC_REG_CTRL: begin
               ctrl_word    = strb_merge(ctrl_word, pwdata, pstrb);
               n.evt        = ctrl_word[CTL_EVT_LSB +: 8];
               n.umask      = ctrl_word[CTL_UM_LSB +: 8];
               n.edge_en    = ctrl_word[CTL_EDGE_BIT];
               n.cnt_en     = ctrl_word[CTL_EN_BIT];
               n.cmask      = ctrl_word[CTL_CMASK_LSB +: 8];
               // fresh selection must not see a stale edge
               n.prev_hit   = 1'b0;
            end
            PESC_REG_CNT_LO: begin
               // software preset beats the increment
               n.count[31:0] = strb_merge(r.count[31:0], pwdata, pstrb);
            end
            PESC_REG_CNT_HI: begin
               hi_word             = strb_merge(hi_word, pwdata, pstrb);
               n.count[CNT_W-1:32] = hi_word[HI_W-1:0];
            end
            PESC_REG_STAT: begin
               // status is read-only; the write is accepted and dropped
               n.last_sum = ev_sum;
            end
         endcase
      end
   end

   // one state register; every field returns to idle under reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r          <= '0;
         r.evt      <= RST_EVT;
         r.umask    <= RST_UMASK;
         r.cmask    <= RST_CMASK;
         r.count    <= RST_COUNT;
         r.pready   <= 1'b0;
         r.pslverr  <= 1'b0;
         r.prdata   <= 32'h0000_0000;
      end else begin
         r <= n;
      end
   end

   assign prdata  = r.prdata;
   assign pready  = r.pready;
   assign pslverr = r.pslverr;

endmodule

// *** bench/pesc_counter_checker.sv ***
`timescale 1ns/100ps
module pesc_counter_checker
   import pesc_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_take;
      psel && $rose(penable);
   endsequence
   sequence s_odd;
      s_take ##0 ((paddr > OFS_STAT) || (paddr[1:0] != 2'h0));
   endsequence
   property p_answer; s_take |=> pready && psel && penable; endproperty
   a_answer: assert property (p_answer) else $error("no answer after one wait");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready held too long");
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   property p_no_req; !(psel && penable) |-> !pready; endproperty
   a_no_req: assert property (p_no_req) else $error("ready without request");
   property p_odd; s_odd |=> pslverr; endproperty
   a_odd: assert property (p_odd) else $error("unmapped address not refused");
   property p_mapped;
      s_take ##0 (paddr <= OFS_STAT && paddr[1:0] == 2'h0) |=> !pslverr;
   endproperty
   a_mapped: assert property (p_mapped) else $error("mapped address refused");
   property p_wr_zero; pready && pwrite |-> prdata == 32'h0; endproperty
   a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
   property p_err_zero; pslverr |-> prdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("refused access returned data");
endmodule

bind pesc_counter pesc_counter_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));

// *** bench/pesc_event_src.sv ***
`timescale 1ns/100ps
// sources are flops in the core, so a plan shows one edge later
module pesc_event_src
   import pesc_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire pesc_events_t plan,
   output pesc_events_t      ev
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev <= '0;
      end else begin
         ev <= plan;
      end
   end
endmodule

// *** bench/tb_perf_event_select_counter.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_perf_event_select_counter;
   import pesc_pkg::*;
   logic         pclk         = 1'h0;
   logic         presetn      = 1'h0;
   logic         psel         = 1'h0;
   logic         penable      = 1'h0;
   logic         pwrite       = 1'h0;
   logic [11:0]  paddr        = 12'h0;
   logic [31:0]  pwdata       = 32'h0;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   pesc_events_t plan         = '0;
   pesc_events_t ev;
   int           fail_count   = 0;
   int           total_checks = 0;
   int           cycles       = 0;

   always #20 pclk = ~pclk;
   pesc_event_src src (.pclk(pclk), .presetn(presetn), .plan(plan), .ev(ev));
   pesc_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ev(ev));

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // the scenarios need under 2000 cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 8000) begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int t;
      t = 0;
      @(posedge pclk);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      // pready is a flop output, settled mid-cycle and standing at the next edge
      do begin
         @(negedge pclk);
         t++;
      end while (pready !== 1'h1 && t < 20);
      `CHK(pready, 1'h1)
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   // counter is cleared after the control write, while sources are quiet
   task automatic meas(input logic [7:0] e, u, c, input logic ed, input int n,
                       input logic [31:0] exp, input pesc_events_t s);
      logic [31:0] d;
      logic        r;
      apb(1'h1, OFS_CTRL, {c, 1'h0, 1'h1, 3'h0, ed, 2'h0, u, e}, d, r);
      apb(1'h1, OFS_CNT_LO, 32'h0, d, r);
      apb(1'h1, OFS_CNT_HI, 32'h0, d, r);
      @(posedge pclk);
      plan <= s;
      repeat (n) @(posedge pclk);
      plan <= '0;
      repeat (4) @(posedge pclk);
      apb(1'h0, OFS_CNT_LO, 32'h0, d, r);
      `CHK(d, exp)
   endtask

   task automatic t_regs();
      logic [31:0] d;
      logic        r;
      apb(1'h0, OFS_CTRL, 32'h0, d, r);
      `CHK(d, 32'h0)
      apb(1'h1, OFS_CTRL, 32'h05440a49, d, r);
      apb(1'h0, OFS_CTRL, 32'h0, d, r);
      `CHK(d, 32'h05440a49)
      apb(1'h0, 12'h010, 32'h0, d, r);
      `CHK({r, d}, 33'h100000000)
      apb(1'h1, OFS_STAT, 32'hffffffff, d, r);
      `CHK(r, 1'h0)
   endtask

   task automatic t_walks();
      pesc_events_t v;
      v = '{walk_done_4k:1, walk_done_2m4m:1, walk_done_1g:1, page_miss_walker_busy_st:1,
            l2x_hit_4k:1, l2x_hit_2m:1, dir_cache_miss_st:1, default:0};
      meas(EV_ST_XLATE, 8'h0e, 8'h0, 1'h0, 4, 32'hc, v);
      meas(EV_ST_XLATE, 8'h10, 8'h0, 1'h0, 5, 32'h5, v);
      meas(EV_ST_XLATE, 8'h40, 8'h0, 1'h0, 3, 32'h3, v);
      meas(EV_ST_XLATE, 8'h60, 8'h0, 1'h0, 3, 32'h6, v);
      meas(EV_ST_XLATE, 8'h80, 8'h0, 1'h0, 2, 32'h2, v);
   endtask

   task automatic t_mem();
      pesc_events_t v;
      v = '{fb_hit_sw_pf:1, fb_hit_hw_pf:1, first_level_line_fill:1, mov_int_elim:1,
            mov_simd_elim:2, mov_int_kept:3, mov_simd_kept:4, lock_l1:1, default:0};
      meas(EV_FB_HIT, 8'h02, 8'h0, 1'h0, 3, 32'h3, v);
      meas(EV_L1_FILL, 8'h01, 8'h0, 1'h0, 6, 32'h6, v);
      meas(EV_MOV_ELIM, 8'h05, 8'h0, 1'h0, 2, 32'h8, v);
      meas(EV_MOV_ELIM, 8'h0a, 8'h0, 1'h0, 2, 32'hc, v);
      meas(EV_LOCK, 8'h01, 8'h0, 1'h0, 3, 32'h0, v);
      meas(EV_LOCK, 8'h02, 8'h0, 1'h0, 3, 32'h3, v);
   endtask

   task automatic t_core();
      pesc_events_t v;
      v = '{unhalted:1, ring0:1, station_empty:1, sq_demand_data:1, sq_demand_code:2,
            sq_rfo:3, sq_all_data:4, default:0};
      meas(EV_RING, 8'h01, 8'h0, 1'h0, 3, 32'h3, v);
      meas(EV_RING, 8'h02, 8'h0, 1'h0, 3, 32'h0, v);
      meas(EV_RING, 8'h01, 8'h0, 1'h1, 3, 32'h1, v);
      meas(EV_RS_EMPTY, 8'h01, 8'h0, 1'h0, 4, 32'h4, v);
      // multithreading is never modelled, so offcore counts stay meaningful
      meas(EV_OFFCORE, 8'h0f, 8'h0, 1'h0, 2, 32'h14, v);
      meas(EV_OFFCORE, 8'h08, 8'h1, 1'h0, 2, 32'h2, v);
   endtask

   task automatic t_decq();
      pesc_events_t v;
      v = '{decq_empty:1, legacy_uops:2, dcache_uops:3, ms_dcache_uops:1, ms_legacy_uops:1,
            default:0};
      meas(EV_DECQ, 8'h02, 8'h0, 1'h0, 3, 32'h3, v);
      meas(EV_DECQ, 8'h0c, 8'h0, 1'h0, 2, 32'ha, v);
      meas(EV_DECQ, 8'h30, 8'h0, 1'h0, 2, 32'h4, v);
      meas(EV_DECQ, 8'h10, 8'h0, 1'h1, 4, 32'h1, v);
      meas(EV_DECQ, 8'h18, 8'h4, 1'h0, 2, 32'h2, v);
      meas(EV_DECQ, 8'h24, 8'h4, 1'h0, 2, 32'h0, v);
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      t_regs();
      t_walks();
      t_mem();
      t_core();
      t_decq();
      wrap_up();
   end
endmodule
